// ---- rtl/ptc_regs.sv ----
// ptc_regs: general control and 10base-t status/control registers
// behind an axi4-lite slave, with the phy status polarity mirror.
// assumes link status and advertisement bits come from logic on aclk;
// strap pins are asynchronous and are synchronised here.
//
// Functional notes
// - auto crossover enable steers crossover; default from strap, nominally one.
// - forced crossover swaps transmit and receive pairs when set.
// - pause receive status from pause resolution, only when full duplex.
// - pause transmit status from pause resolution, only when full duplex.
// - link status bit is one only for autonegotiated 100 full duplex.
// - reserved bits ignore writes and read as zero.
// - led stretch bypass makes led follow raw indication.
// - station address is read-only, latched from strap, default one.
// - receiver threshold bit selects lower 10base-t threshold.
// - four-bit squelch field, 50 mV steps, reset selects 200 mV.
// - link pulse disable bit stops normal link pulses.
// - polarity bit shows inverted polarity, mirrored in phy status.
// - reading 10base-t register clears both polarity bits; status read not.
// - jabber disable bit, effective only in 10base-t operation.
`timescale 1ns/10ps
module ptc_regs
  import ptc_pkg::*;
#(
  parameter int TICK_CYC = CLK_KHZ
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire ptc_strap_t strap_i,
  input wire ptc_pause_adv_t local_adv_i,
  input wire ptc_pause_adv_t partner_adv_i,
  input wire ptc_link_stat_t stat_i,
  output ptc_cfg_t cfg_o,
  output logic pause_rx_o,
  output logic pause_tx_o,
  output logic link_indicator_output
);
  localparam logic [ADDR_W-1:0] PS_ADDR = {PS_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] GC_ADDR = {GC_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] TS_ADDR = {TS_IDX, 2'b00};

  ptc_strap_t strap_m_q;
  ptc_strap_t strap_s_q;
  logic strap_done_q;
  logic auto_q;
  logic force_q;
  logic byp_q;
  logic led_q;
  logic [4:0] addr_q;
  logic rxth_q;
  logic [3:0] sq_q;
  logic nlp_q;
  logic jab_q;
  logic pol_q;
  logic prx_q;
  logic ptx_q;
  logic link_q;
  logic jab_act_q;
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_en;
  logic rd_en;
  logic rd_ts;
  logic [15:0] gc_rd;
  logic [15:0] ts_rd;
  logic [15:0] ps_rd;
  logic res_both;
  logic res_tx;
  logic res_rx;

  // strap pins are asynchronous: two flops before use
  always_ff @(posedge aclk)
  begin
    strap_m_q <= strap_i;
    strap_s_q <= strap_m_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      strap_done_q <= 1'b0;
    else
      strap_done_q <= 1'b1;
  end

  // axi write channels taken independently, write when both held
  assign awready = !aw_held_q && !bvalid;
  assign wready = !w_held_q && !bvalid;
  assign wr_en = aw_held_q && w_held_q && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (awvalid && awready)
    begin
      aw_held_q <= 1'b1;
      awaddr_q <= awaddr;
    end
    else if (wr_en)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_held_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end
    else if (wr_en)
      w_held_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OK;
    end
    else if (wr_en)
    begin
      bvalid <= 1'b1;
      bresp <= (awaddr_q == GC_ADDR || awaddr_q == TS_ADDR ||
                awaddr_q == PS_ADDR) ? RESP_OK : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // general control: only writable bits stored, addr is read-only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      auto_q <= AUTO_RST;
      force_q <= 1'b0;
      byp_q <= 1'b0;
      led_q <= 1'b0;
      addr_q <= ADDR_RST;
    end
    else if (!strap_done_q)
    begin
      auto_q <= strap_s_q.auto_mdix;
      led_q <= strap_s_q.led_mode_select;
      addr_q <= strap_s_q.addr;
    end
    else if (wr_en && awaddr_q == GC_ADDR)
    begin
      if (wstrb_q[1])
      begin
        auto_q <= wdata_q[GC_AUTO];
        force_q <= wdata_q[GC_FORCE];
      end
      if (wstrb_q[0])
      begin
        byp_q <= wdata_q[GC_BYP];
        led_q <= wdata_q[GC_LED];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rxth_q <= 1'b0;
      sq_q <= SQ_RST;
      nlp_q <= 1'b0;
      jab_q <= 1'b0;
    end
    else if (wr_en && awaddr_q == TS_ADDR)
    begin
      if (wstrb_q[1])
      begin
        rxth_q <= wdata_q[TS_RXTH];
        sq_q <= wdata_q[TS_SQ_LSB +: 4];
      end
      if (wstrb_q[0])
      begin
        nlp_q <= wdata_q[TS_NLP];
        jab_q <= wdata_q[TS_JAB];
      end
    end
  end

  // pause resolution from the local and partner pause/asym bits
  assign res_both = local_adv_i.pause && partner_adv_i.pause;
  assign res_tx = res_both || (!local_adv_i.pause && local_adv_i.asym_dir &&
                  partner_adv_i.pause && partner_adv_i.asym_dir);
  assign res_rx = res_both || (local_adv_i.pause && local_adv_i.asym_dir &&
                  !partner_adv_i.pause && partner_adv_i.asym_dir);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prx_q <= 1'b0;
      ptx_q <= 1'b0;
      link_q <= 1'b0;
      jab_act_q <= 1'b0;
    end
    else
    begin
      prx_q <= res_rx && stat_i.an_done && stat_i.full_dup;
      ptx_q <= res_tx && stat_i.an_done && stat_i.full_dup;
      link_q <= stat_i.link_up && stat_i.an_done && stat_i.speed100 &&
                stat_i.full_dup;
      jab_act_q <= !jab_q && !stat_i.speed100;
    end
  end

  // polarity flag: detection wins over the clear by a read
  assign rd_en = arvalid && arready;
  assign rd_ts = rd_en && araddr == TS_ADDR;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pol_q <= 1'b0;
    else if (stat_i.pol_inv)
      pol_q <= 1'b1;
    else if (rd_ts)
      pol_q <= 1'b0;
  end

  // read views; reserved bits are zero by construction
  always_comb
  begin
    gc_rd = 16'h0;
    gc_rd[GC_AUTO] = auto_q;
    gc_rd[GC_FORCE] = force_q;
    gc_rd[GC_PRX] = prx_q;
    gc_rd[GC_PTX] = ptx_q;
    gc_rd[GC_LINK] = link_q;
    gc_rd[GC_BYP] = byp_q;
    gc_rd[GC_LED] = led_q;
    gc_rd[GC_ADDR_LSB +: 5] = addr_q;
    ts_rd = 16'h0;
    ts_rd[TS_RXTH] = rxth_q;
    ts_rd[TS_SQ_LSB +: 4] = sq_q;
    ts_rd[TS_NLP] = nlp_q;
    ts_rd[TS_POL] = pol_q;
    ts_rd[TS_JAB] = jab_q;
    ps_rd = 16'h0;
    ps_rd[PS_POL] = pol_q;
  end

  assign arready = !rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OK;
    end
    else if (rd_en)
    begin
      rvalid <= 1'b1;
      rresp <= RESP_OK;
      case (araddr)
        GC_ADDR: rdata <= {16'h0, gc_rd};
        TS_ADDR: rdata <= {16'h0, ts_rd};
        PS_ADDR: rdata <= {16'h0, ps_rd};
        default:
        begin
          rdata <= '0;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  assign cfg_o.mdix_auto_en = auto_q;
  assign cfg_o.mdix_force = force_q;
  assign cfg_o.rx_thresh_low = rxth_q;
  assign cfg_o.squelch = sq_q;
  assign cfg_o.nlp_disable = nlp_q;
  assign cfg_o.jabber_active = jab_act_q;
  assign pause_rx_o = prx_q;
  assign pause_tx_o = ptx_q;

  ptc_led #(.TICK_CYC(TICK_CYC)) u_led
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .link_i(stat_i.link_up),
    .act_i(stat_i.activity),
    .bypass_i(byp_q),
    .led_mode_select_i(led_q),
    .led_o(link_indicator_output)
  );

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_mdix_auto_wr: assert property ((wr_en && awaddr_q == GC_ADDR &&
    wstrb_q[1] && strap_done_q) |=> cfg_o.mdix_auto_en ==
    $past(wdata_q[GC_AUTO]))
    else $error("auto crossover not written");
  a_mdix_force_wr: assert property ((wr_en && awaddr_q == GC_ADDR &&
    wstrb_q[1] && strap_done_q) |=> cfg_o.mdix_force ==
    $past(wdata_q[GC_FORCE]))
    else $error("forced crossover not written");
  a_pause_rx_fd: assert property (!stat_i.full_dup |=> !pause_rx_o)
    else $error("pause rx set without full duplex");
  a_pause_tx_both: assert property ((res_both && stat_i.an_done &&
    stat_i.full_dup) |=> pause_tx_o && pause_rx_o)
    else $error("pause tx not resolved");
  a_link_stat: assert property (!stat_i.speed100 |=> !link_q)
    else $error("link status set outside 100 mb/s");
  a_reserved_zero: assert property ((rd_en && araddr == GC_ADDR) |=>
    rdata[10:8] == 3'h0 && rdata[31:16] == 16'h0)
    else $error("reserved bits not zero");
  a_addr_ro: assert property ((strap_done_q && wr_en) |=> $stable(addr_q))
    else $error("station address changed by write");
  a_pol_set: assert property (stat_i.pol_inv |=> pol_q && ts_rd[TS_POL] && ps_rd[PS_POL])
    else $error("polarity not captured");
  a_pol_clear: assert property ((rd_ts && !stat_i.pol_inv) |=>
    !pol_q && !ps_rd[PS_POL])
    else $error("polarity not cleared by read");
  a_pol_keep: assert property ((rd_en && araddr == PS_ADDR && pol_q) |=>
    pol_q)
    else $error("status read cleared polarity");
  a_jabber_100: assert property (stat_i.speed100 |=> !cfg_o.jabber_active)
    else $error("jabber active in 100 mb/s");

  c_write_gc: cover property (wr_en && awaddr_q == GC_ADDR);
  c_read_pol: cover property (rd_ts && pol_q);
  c_bad_write: cover property (bvalid && bresp == RESP_SLVERR);
endmodule // ptc_regs

// ---- inc/ptc_pkg.sv ----
// ptc_pkg: constants, register layout and carrier types for the phy
// general control and 10base-t status/control register block.
// assumes a 40 MHz aclk and an 8-bit axi4-lite byte address.
package ptc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [5:0] PS_IDX = 6'h10;
  localparam logic [5:0] GC_IDX = 6'h19;
  localparam logic [5:0] TS_IDX = 6'h1A;

  // general control bits
  localparam int GC_AUTO = 15;
  localparam int GC_FORCE = 14;
  localparam int GC_PRX = 13;
  localparam int GC_PTX = 12;
  localparam int GC_LINK = 11;
  localparam int GC_BYP = 7;
  localparam int GC_LED = 5;
  localparam int GC_ADDR_LSB = 0;

  // 10base-t status/control bits
  localparam int TS_RXTH = 13;
  localparam int TS_SQ_LSB = 9;
  localparam int TS_NLP = 7;
  localparam int TS_POL = 4;
  localparam int TS_JAB = 0;

  // phy status register polarity mirror
  localparam int PS_POL = 12;

  localparam logic [3:0] SQ_RST = 4'h0;
  localparam logic [4:0] ADDR_RST = 5'h01;
  localparam logic AUTO_RST = 1'b1;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // led timing
  localparam int CLK_KHZ = 40000;
  localparam int LED_STRETCH_MS = 50;
  localparam int LED_BLINK_MS = 100;

  typedef struct packed {
    logic auto_mdix;
    logic led_mode_select;
    logic [4:0] addr;
  } ptc_strap_t;

  typedef struct packed {
    logic asym_dir;
    logic pause;
  } ptc_pause_adv_t;

  typedef struct packed {
    logic link_up;
    logic an_done;
    logic speed100;
    logic full_dup;
    logic pol_inv;
    logic activity;
  } ptc_link_stat_t;

  typedef struct packed {
    logic mdix_auto_en;
    logic mdix_force;
    logic rx_thresh_low;
    logic [3:0] squelch;
    logic nlp_disable;
    logic jabber_active;
  } ptc_cfg_t;

endpackage

// ---- rtl/ptc_led.sv ----
// ptc_link_indicator_output indicator driver with activity stretch and blink.
// assumes link and activity levels come from logic on aclk.
`timescale 1ns/10ps
module ptc_led
  import ptc_pkg::*;
#(
  parameter int TICK_CYC = CLK_KHZ
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_i,
  input wire logic act_i,
  input wire logic bypass_i,
  input wire logic led_mode_select_i,
  output logic led_o
);
  logic [31:0] div_q;
  logic tick;
  logic [7:0] str_q;
  logic [7:0] blk_q;
  logic phase_q;
  logic act_s;

  // one pulse per millisecond keeps the stretch counters small
  assign tick = (div_q == 32'(TICK_CYC - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick)
      div_q <= 32'h0;
    else
      div_q <= div_q + 32'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      str_q <= 8'h0;
    else if (act_i)
      str_q <= 8'(LED_STRETCH_MS);
    else if (tick && str_q != 8'h0)
      str_q <= str_q - 8'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      blk_q <= 8'h0;
      phase_q <= 1'b1;
    end
    else if (!act_s)
    begin
      blk_q <= 8'h0;
      phase_q <= 1'b1;
    end
    else if (tick)
    begin
      if (blk_q == 8'(LED_BLINK_MS - 1))
      begin
        blk_q <= 8'h0;
        phase_q <= ~phase_q;
      end
      else
        blk_q <= blk_q + 8'h1;
    end
  end

  // bypass shows the raw activity level with no stretching
  assign act_s = bypass_i ? act_i : (act_i || str_q != 8'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      led_o <= 1'b0;
    else if (led_mode_select_i)
      led_o <= link_i;
    else
      led_o <= link_i && (bypass_i ? !act_s : (!act_s || phase_q));
  end
endmodule // ptc_led

// ---- test/ptc_host.sv ----
// ptc_host: axi4-lite management host model with one write and one read
// task; assumes the slave sits on aclk and answers within LIMIT cycles.
`timescale 1ns/10ps
module ptc_host
  import ptc_pkg::*;
(
  input wire logic aclk,
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  localparam int LIMIT = 200;
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // handshakes are judged at the falling edge so the combinational readys
  // are not raced against the rising-edge register updates
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    int n;
    logic ta, tw, tv;
    n = 0;
    tv = 1'b0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tv && n < LIMIT)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tv = bvalid;
      r = bresp;
      @(posedge aclk);
      // released payload is inverted so a stale value never looks valid
      if (ta) {awvalid, awaddr} <= {1'b0, ~a};
      if (tw) {wvalid, wdata} <= {1'b0, ~d};
      n++;
    end
    bready <= 1'b0;
    // one idle edge so a following call never re-drives bready in this step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    int n;
    logic ta, tv;
    n = 0;
    tv = 1'b0;
    d = '0;
    r = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tv && n < LIMIT)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) {arvalid, araddr} <= {1'b0, ~a};
      n++;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule // ptc_host

// ---- test/tb.sv ----
// tb: register tests for ptc_regs through the ptc_host model.
// assumes a 40 MHz aclk and a shortened led tick of 4 cycles.
`timescale 1ns/10ps
module tb
  import ptc_pkg::*;
;
  localparam logic [7:0] GC_A = {GC_IDX, 2'b00};
  localparam logic [7:0] TS_A = {TS_IDX, 2'b00};
  localparam logic [7:0] PS_A = {PS_IDX, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  ptc_strap_t strap_i = 7'h6B;
  ptc_pause_adv_t local_adv_i = 2'h0;
  ptc_pause_adv_t partner_adv_i = 2'h0;
  ptc_link_stat_t stat_i = 6'h00;
  ptc_cfg_t cfg_o;
  logic pause_rx_o, pause_tx_o, led;
  int err_total = 0;
  int checked = 0;
  // pause table rows {local, partner, full duplex, expected rx tx}
  logic [6:0] pt [5] = '{7'h2F, 7'h5D, 7'h76, 7'h24, 7'h28};
  always #12.5 aclk = ~aclk;
  ptc_regs #(.TICK_CYC(4)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .strap_i(strap_i),
    .local_adv_i(local_adv_i), .partner_adv_i(partner_adv_i),
    .stat_i(stat_i), .cfg_o(cfg_o), .pause_rx_o(pause_rx_o),
    .pause_tx_o(pause_tx_o), .link_indicator_output(led));
  ptc_host host_u (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    host_u.rd(a, d, r);
    chk({r, d}, {er, e});
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic [1:0] r;
    host_u.wr(a, d, 4'hF, r);
    chk({32'h0, r}, {32'h0, er});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic print_verdict(input bit hung);
    if (hung) err_total++;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    tick(30000);
    print_verdict(1'b1);
  end
  initial
  begin
    logic [6:0] e;
    int lows;
    lows = 0;
    tick(8);
    aresetn <= 1'b1;
    tick(1);
    rdc(GC_A, 32'h802B, RESP_OK);
    rdc(TS_A, 32'h0, RESP_OK);
    chk({25'h0, cfg_o}, 34'h101);
    $display("test reset done");
    wrc(GC_A, 32'hFFFF_FFFF, RESP_OK);
    rdc(GC_A, 32'hC0AB, RESP_OK);
    chk({25'h0, cfg_o}, 34'h181);
    wrc(GC_A, 32'h0, RESP_OK);
    rdc(GC_A, 32'h000B, RESP_OK);
    chk({25'h0, cfg_o}, 34'h001);
    wrc(TS_A, 32'hFFFF_FFFF, RESP_OK);
    rdc(TS_A, 32'h3E81, RESP_OK);
    chk({25'h0, cfg_o}, 34'h07E);
    wrc(TS_A, 32'h0, RESP_OK);
    chk({25'h0, cfg_o}, 34'h001);
    $display("test control done");
    for (int i = 0; i < 5; i++)
    begin
      e = pt[i];
      local_adv_i <= e[6:5];
      partner_adv_i <= e[4:3];
      stat_i <= {3'h7, e[2], 2'b00};
      tick(3);
      chk({32'h0, pause_rx_o, pause_tx_o}, {32'h0, e[1:0]});
      rdc(GC_A, {18'h0, e[1:0], e[2], 11'h00B}, RESP_OK);
    end
    $display("test pause done");
    stat_i <= 6'h02;
    tick(1);
    stat_i.pol_inv <= 1'b0;
    tick(2);
    rdc(PS_A, 32'h1000, RESP_OK);
    rdc(PS_A, 32'h1000, RESP_OK);
    rdc(TS_A, 32'h0010, RESP_OK);
    rdc(TS_A, 32'h0, RESP_OK);
    rdc(PS_A, 32'h0, RESP_OK);
    rdc(8'h00, 32'h0, RESP_SLVERR);
    wrc(8'h04, 32'hFFFF_FFFF, RESP_SLVERR);
    rdc(GC_A, 32'h000B, RESP_OK);
    $display("test polarity done");
    wrc(GC_A, 32'h20, RESP_OK);
    stat_i <= 6'h21;
    tick(4);
    chk({33'h0, led}, 34'h1);
    stat_i.link_up <= 1'b0;
    tick(4);
    chk({33'h0, led}, 34'h0);
    wrc(GC_A, 32'h80, RESP_OK);
    stat_i <= 6'h21;
    tick(4);
    chk({33'h0, led}, 34'h0);
    stat_i.activity <= 1'b0;
    tick(4);
    chk({33'h0, led}, 34'h1);
    // a blink half period is 400 cycles at this tick, so 1000 shows one
    wrc(GC_A, 32'h0, RESP_OK);
    stat_i.activity <= 1'b1;
    repeat (1000)
    begin
      @(posedge aclk);
      if (led !== 1'b1) lows++;
    end
    chk({33'h0, lows > 0}, 34'h1);
    $display("test led done");
    print_verdict(1'b0);
  end
endmodule // tb
